// ---- rtl/aisa_cfg.svh ----
// register map, field positions and reset values of the supply and input alarm block
`ifndef AISA_CFG_SVH
`define AISA_CFG_SVH
`define AISA_ADDR_W            8
`define AISA_ADDR_STATUS       8'h20
`define AISA_ADDR_HIGH_TH      8'h24
`define AISA_ADDR_LOW_TH       8'h28
`define AISA_BIT_ACT_SUP_LOW   15
`define AISA_BIT_ACT_SUP_HIGH  14
`define AISA_BIT_ACT_IN_HIGH   11
`define AISA_BIT_ACT_IN_LOW    10
`define AISA_BIT_LAT_SUP_LOW   7
`define AISA_BIT_LAT_SUP_HIGH  6
`define AISA_BIT_LAT_IN_HIGH   5
`define AISA_BIT_LAT_IN_LOW    4
`define AISA_BIT_ANY           0
`define AISA_HIGH_TH_RESET     16'hFFFF
`define AISA_LOW_TH_RESET      16'h0000
`define AISA_HYST_RESET        8'h00
`define AISA_CMP_LSB           2
`define AISA_HYST_LSB          4
`endif

// ---- rtl/aisa_input_cmp.sv ----
// one hysteretic input limit comparator
`timescale 1ns/1ps
`include "aisa_cfg.svh"
module aisa_input_cmp (
  input  wire logic        clk,      // conversion clock
  input  wire logic        srst,     // synchronous reset
  input  wire logic        upper,    // 1: trip above limit, 0: below
  input  wire logic        sample,   // new result this cycle
  input  wire logic [13:0] code,     // result, compared bits
  input  wire logic [13:0] limit,    // limit, compared bits
  input  wire logic [3:0]  hyst,     // hysteresis in result codes
  output logic             active    // present alarm
);
  logic [14:0] rel_lim;

  // release point moved inside the limit by the hysteresis
  always_comb begin
    if (upper) begin
      rel_lim = {1'b0, limit} - {11'h000, hyst};
    end else begin
      rel_lim = {1'b0, limit} + {11'h000, hyst};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      active <= 1'b0;
    end else if (sample) begin
      if (upper) begin
        if (code > limit) begin
          active <= 1'b1;
        end else if (rel_lim[14] || ({1'b0, code} <= rel_lim)) begin
          active <= 1'b0;
        end
      end else begin
        if (code < limit) begin
          active <= 1'b1;
        end else if (!rel_lim[14] && ({1'b0, code} >= rel_lim)) begin
          active <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- rtl/aisa_pkg.sv ----
// types shared by the supply and input alarm block
package aisa_pkg;
  typedef struct packed {
    logic        valid;
    logic [15:0] code;
  } aisa_sample_t;

  typedef struct packed {
    logic sup_low;
    logic sup_high;
    logic in_high;
    logic in_low;
  } aisa_flags_t;
endpackage

// ---- rtl/aisa_sync.sv ----
// two-stage synchroniser for the analog supply comparator levels
`timescale 1ns/1ps
module aisa_sync (
  input  wire logic       clk,    // conversion clock
  input  wire logic       srst,   // synchronous reset
  input  wire logic [1:0] d,      // asynchronous levels
  output logic      [1:0] q       // synchronised levels
);
  logic [1:0] meta_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= 2'h0;
      q      <= 2'h0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ---- rtl/aisa_top.sv ----
// alarm monitor: input limits with hysteresis, supply alarms, status and threshold registers
//
// Operation
// - status bit 15 shows present low analog supply alarm.
// - status bit 14 shows present high analog supply alarm.
// - status bits 11 and 10 show present high and low input alarms.
// - status bits 7 and 6 hold latched low and high supply alarms.
// - status bits 5 and 4 hold latched high and low input alarms.
// - present flags read one while alarm exists, zero otherwise; all reset zero.
// - status bit 0 is the OR of every latched flag.
// - reserved status bits always read zero.
// - high threshold bits 31-24 hold hysteresis; upper nibble is used.
// - upper limit at bits 15-0, resets all ones, bits 15-2 compared.
// - lower limit at bits 15-0, resets zero, bits 15-2 compared.
// - high threshold register occupies byte addresses 24h to 27h.
// - low threshold register occupies 28h to 2Bh, upper half reads zero.
// - status register occupies byte addresses 20h to 23h.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "aisa_cfg.svh"
module aisa_top (
  input  wire logic                     clk,              // conversion clock, 50 MHz
  input  wire logic                     srst,             // synchronous reset, active high
  input  wire logic [`AISA_ADDR_W-1:0]  reg_addr,         // byte address
  input  wire logic [7:0]               reg_wdata,        // write byte
  input  wire logic                     reg_wr,           // write strobe
  input  wire logic                     reg_rd,           // read strobe
  output logic      [7:0]               reg_rdata,        // read byte, cycle after strobe
  input  wire aisa_pkg::aisa_sample_t   sample_in,        // conversion result
  input  wire logic                     supply_low_raw,   // analog_supply low comparator
  input  wire logic                     supply_high_raw,  // analog_supply high comparator
  output aisa_pkg::aisa_flags_t         active_flags,     // present flags
  output logic                          any_latched_alarm // OR of latched flags
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0]          input_upper_limit_r;
  logic [15:0]          input_lower_limit_r;
  logic [7:0]           input_alarm_hysteresis_r;
  logic [1:0]           supply_sync;
  logic                 in_high_act;
  logic                 in_low_act;
  logic                 latched_supply_low_r;
  logic                 latched_supply_high_r;
  logic                 latched_input_high_r;
  logic                 latched_input_low_r;
  logic [31:0]          status_word;
  logic [31:0]          high_word;
  logic [31:0]          low_word;
  logic                 status_rd;

  // byte lane selector of a word register
  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] lane);
    byte_of = w[{lane, 3'h0} +: 8];
  endfunction

  // word base decode
  function automatic logic hit(input logic [`AISA_ADDR_W-1:0] a, input logic [`AISA_ADDR_W-1:0] base);
    hit = (a[`AISA_ADDR_W-1:2] == base[`AISA_ADDR_W-1:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  aisa_sync u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({supply_low_raw, supply_high_raw}),
    .q    (supply_sync)
  );

  aisa_input_cmp u_cmp_high (
    .clk    (clk),
    .srst   (srst),
    .upper  (1'b1),
    .sample (sample_in.valid),
    .code   (sample_in.code[15:`AISA_CMP_LSB]),
    .limit  (input_upper_limit_r[15:`AISA_CMP_LSB]),
    .hyst   (input_alarm_hysteresis_r[7:`AISA_HYST_LSB]),
    .active (in_high_act)
  );

  aisa_input_cmp u_cmp_low (
    .clk    (clk),
    .srst   (srst),
    .upper  (1'b0),
    .sample (sample_in.valid),
    .code   (sample_in.code[15:`AISA_CMP_LSB]),
    .limit  (input_lower_limit_r[15:`AISA_CMP_LSB]),
    .hyst   (input_alarm_hysteresis_r[7:`AISA_HYST_LSB]),
    .active (in_low_act)
  );

  ////////////////////////////////////////////////////////////////////////////
  // threshold register writes, byte by byte
  always_ff @(posedge clk) begin
    if (srst) begin
      input_upper_limit_r      <= `AISA_HIGH_TH_RESET;
      input_alarm_hysteresis_r <= `AISA_HYST_RESET;
    end else if (reg_wr && hit(reg_addr, `AISA_ADDR_HIGH_TH)) begin
      unique case (reg_addr[1:0])
        2'h0: begin
          input_upper_limit_r[7:0] <= reg_wdata;
        end
        2'h1: begin
          input_upper_limit_r[15:8] <= reg_wdata;
        end
        2'h2: begin
        end
        2'h3: begin
          input_alarm_hysteresis_r <= reg_wdata;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      input_lower_limit_r <= `AISA_LOW_TH_RESET;
    end else if (reg_wr && hit(reg_addr, `AISA_ADDR_LOW_TH)) begin
      if (reg_addr[1:0] == 2'h0) begin
        input_lower_limit_r[7:0] <= reg_wdata;
      end else if (reg_addr[1:0] == 2'h1) begin
        input_lower_limit_r[15:8] <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched flags: an alarm present in the read cycle survives the clear
  assign status_rd = reg_rd && hit(reg_addr, `AISA_ADDR_STATUS);

  always_ff @(posedge clk) begin
    if (srst) begin
      latched_supply_low_r  <= 1'b0;
      latched_supply_high_r <= 1'b0;
      latched_input_high_r  <= 1'b0;
      latched_input_low_r   <= 1'b0;
    end else begin
      latched_supply_low_r  <= supply_sync[1] | (latched_supply_low_r & ~status_rd);
      latched_supply_high_r <= supply_sync[0] | (latched_supply_high_r & ~status_rd);
      latched_input_high_r  <= in_high_act | (latched_input_high_r & ~status_rd);
      latched_input_low_r   <= in_low_act | (latched_input_low_r & ~status_rd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`AISA_BIT_ACT_SUP_LOW]  = supply_sync[1];
    status_word[`AISA_BIT_ACT_SUP_HIGH] = supply_sync[0];
    status_word[`AISA_BIT_ACT_IN_HIGH]  = in_high_act;
    status_word[`AISA_BIT_ACT_IN_LOW]   = in_low_act;
    status_word[`AISA_BIT_LAT_SUP_LOW]  = latched_supply_low_r;
    status_word[`AISA_BIT_LAT_SUP_HIGH] = latched_supply_high_r;
    status_word[`AISA_BIT_LAT_IN_HIGH]  = latched_input_high_r;
    status_word[`AISA_BIT_LAT_IN_LOW]   = latched_input_low_r;
    status_word[`AISA_BIT_ANY]          = any_latched_alarm;
  end

  assign high_word = {input_alarm_hysteresis_r, 8'h00, input_upper_limit_r};
  assign low_word  = {16'h0000, input_lower_limit_r};

  assign any_latched_alarm = latched_supply_low_r | latched_supply_high_r |
                             latched_input_high_r | latched_input_low_r;

  assign active_flags.sup_low  = supply_sync[1];
  assign active_flags.sup_high = supply_sync[0];
  assign active_flags.in_high  = in_high_act;
  assign active_flags.in_low   = in_low_act;

  ////////////////////////////////////////////////////////////////////////////
  // read data registered; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (status_rd) begin
        reg_rdata <= byte_of(status_word, reg_addr[1:0]);
      end else if (hit(reg_addr, `AISA_ADDR_HIGH_TH)) begin
        reg_rdata <= byte_of(high_word, reg_addr[1:0]);
      end else if (hit(reg_addr, `AISA_ADDR_LOW_TH)) begin
        reg_rdata <= byte_of(low_word, reg_addr[1:0]);
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// ---- verification/aisa_host_model.sv ----
// host controller model: byte writes and reads
`timescale 1ns/1ps
module aisa_host_model (
  input  wire logic       clk,   // clock
  input  wire logic [7:0] rdata, // read byte
  output logic      [7:0] addr,  // address
  output logic      [7:0] wdata, // write byte
  output logic            wr,    // write strobe
  output logic            rd     // read strobe
);
  initial {addr, wdata, wr, rd} = 18'h0;
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    {addr, wdata, wr} <= {~a, ~d, 1'b0};
  endtask
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    {addr, rd} <= {~a, 1'b0};
    // read data stand only until the next rising edge
    @(negedge clk);
    d = rdata;
  endtask
endmodule

// ---- verification/aisa_props.sv ----
// checker of the alarm monitor ports
`timescale 1ns/1ps
module aisa_props (
  input wire logic                   clk,              // clock
  input wire logic                   srst,             // reset
  input wire logic [7:0]             reg_addr,         // address
  input wire logic [7:0]             reg_wdata,        // write byte
  input wire logic                   reg_wr,           // write strobe
  input wire logic                   reg_rd,           // read strobe
  input wire logic [7:0]             reg_rdata,        // read byte
  input wire aisa_pkg::aisa_sample_t sample_in,        // result
  input wire logic                   supply_low_raw,   // supply low
  input wire logic                   supply_high_raw,  // supply high
  input wire aisa_pkg::aisa_flags_t  active_flags,     // present flags
  input wire logic                   any_latched_alarm // latched OR
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic st_rd;
  assign st_rd = reg_rd && reg_addr[7:2] == 6'h08;
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer");
  a_stat_hi_bits: assert property (reg_rd && reg_addr == 8'h21 |=>
    reg_rdata == {$past(active_flags.sup_low), $past(active_flags.sup_high), 2'b00,
    $past(active_flags.in_high), $past(active_flags.in_low), 2'b00})
    else $error("status high byte wrong");
  a_stat_lo_bits: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata[3:0] == {3'b000, $past(any_latched_alarm)})
    else $error("status low byte wrong");
  a_rsvd_zero: assert property (reg_rd && reg_addr inside {8'h22, 8'h23, 8'h26, 8'h2A, 8'h2B} |=> reg_rdata == 8'h00)
    else $error("reserved byte not zero");
  a_sup_low_rise: assert property ($rose(active_flags.sup_low) |-> $past(supply_low_raw, 2))
    else $error("supply low flag without cause");
  a_sup_high_fall: assert property ($fell(active_flags.sup_high) |-> !$past(supply_high_raw, 2))
    else $error("supply high flag dropped early");
  a_latch_on_act: assert property ($rose(|active_flags) |-> ##[1:2] any_latched_alarm)
    else $error("alarm not latched");
  a_latch_hold: assert property (any_latched_alarm && !st_rd |=> any_latched_alarm)
    else $error("latched alarm lost");
  a_read_clear: assert property (st_rd && active_flags == 4'h0 |=> !any_latched_alarm)
    else $error("latched alarm not cleared");
  a_act_stable: assert property (!$past(sample_in.valid) |-> $stable({active_flags.in_high, active_flags.in_low}))
    else $error("input flag moved without result");
  c_clear: cover property (st_rd && any_latched_alarm);
  c_in_high: cover property ($rose(active_flags.in_high));
  c_sup_low: cover property ($rose(active_flags.sup_low));
endmodule
bind aisa_top aisa_props aisa_props_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_in(sample_in), .supply_low_raw(supply_low_raw),
  .supply_high_raw(supply_high_raw), .active_flags(active_flags), .any_latched_alarm(any_latched_alarm));

// ---- verification/aisa_top_tb.sv ----
// self-checking bench of the alarm monitor
`timescale 1ns/1ps
module aisa_top_tb;
  logic                   clk, srst, s_lo, s_hi, any_al, wr, rd;
  logic                   ah, al, lh, ll, lsl, lsh, sl, sh;
  logic [7:0]             addr, wdata, rdata, got;
  aisa_pkg::aisa_sample_t smp;
  aisa_pkg::aisa_flags_t  act;
  int                     num_errors, cmp_count, cyc, seed, hi, lo, hy, i, j;
  aisa_top aisa_top_inst (.clk(clk), .srst(srst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .sample_in(smp), .supply_low_raw(s_lo), .supply_high_raw(s_hi), .active_flags(act),
    .any_latched_alarm(any_al));
  aisa_host_model aisa_host_model_inst (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_sim();
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    aisa_host_model_inst.wr_byte(a, d);
  endtask
  // status reads leave only present alarms latched
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    aisa_host_model_inst.rd_byte(a, got);
    chk(got, e);
    if (a[7:2] == 6'h08) {lsl, lsh, lh, ll} = {sl, sh, ah, al};
  endtask
  task automatic status();
    chk({4'h0, act}, {4'h0, sl, sh, ah, al});
    chk({7'h0, any_al}, {7'h0, |{lsl, lsh, lh, ll}});
    rd_chk(8'h20, {lsl, lsh, lh, ll, 3'b000, |{lsl, lsh, lh, ll}});
    rd_chk(8'h21, {sl, sh, 2'b00, ah, al, 2'b00});
    rd_chk(8'h23, 8'h00);
  endtask
  // reference: limits and hysteresis in units of code bits 15:2
  task automatic samp(input int v);
    int k;
    k = (v & 32'hFFFF) >> 2;
    @(posedge clk);
    smp <= {1'b1, v[15:0]};
    @(posedge clk);
    smp <= {1'b0, ~v[15:0]};
    repeat (3) @(posedge clk);
    if (k > hi >> 2) ah = 1'b1;
    else if (k <= ((hi >> 2) > hy ? (hi >> 2) - hy : 0)) ah = 1'b0;
    if (k < lo >> 2) al = 1'b1;
    else if (k >= (lo >> 2) + hy) al = 1'b0;
    lh = lh | ah;
    ll = ll | al;
  endtask
  task automatic supply(input logic l, input logic h);
    @(posedge clk);
    {s_lo, s_hi} <= {l, h};
    repeat (4) @(posedge clk);
    {sl, sh} = {l, h};
    {lsl, lsh} = {lsl | l, lsh | h};
  endtask
  initial begin
    seed = 32'hdee5;
    {srst, s_lo, s_hi} = 3'b100;
    smp = '0;
    {ah, al, lh, ll, lsl, lsh, sl, sh} = 8'h00;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (i = 8'h1F; i < 8'h2D; i++) rd_chk(i[7:0], (i == 8'h24 || i == 8'h25) ? 8'hFF : 8'h00);
    for (j = 0; j < 3; j++) begin
      lo = $random(seed) & 32'h7FFC;
      hi = ($random(seed) & 32'h7FFC) | 32'h8000;
      hy = $random(seed) & 15;
      w(8'h24, hi[7:0]);
      w(8'h25, hi[15:8]);
      w(8'h27, {hy[3:0], 4'h0});
      w(8'h28, lo[7:0]);
      w(8'h29, lo[15:8]);
      w(8'h26, 8'h3C);
      w(8'h2A, 8'hA5);
      w(8'h20, 8'hFF);
      rd_chk(8'h25, hi[15:8]);
      rd_chk(8'h27, {hy[3:0], 4'h0});
      rd_chk(8'h26, 8'h00);
      rd_chk(8'h2A, 8'h00);
      rd_chk(8'h28, lo[7:0]);
      for (i = 0; i < 16; i++) begin
        samp(((i & 1) ? hi : lo) + $random(seed) % 96);
        if (i % 3 == 0) status();
      end
      status();
    end
    supply(1'b1, 1'b0);
    status();
    supply(1'b0, 1'b1);
    status();
    supply(1'b0, 1'b0);
    status();
    status();
    end_sim();
  end
endmodule
